/* hdl/src_reset_ctrl.sv */
/*
 system reset controller: gathers seven reset sources, stretches them
 into a chip reset, records the cause, and fetches the boot stack
 pointer and reset entry from the fixed vector table.
 assumes rst_b comes from an analog power-on detector, the other
 sources are levels or pulses, and a memory port answers fetches in
 fixed one cycle.
*/
// Implementation choices: the register offsets and the Avalon-MM register port.
`include "src_consts.svh"
module src_reset_ctrl #(
   parameter int HOLD_CYC = `SRC_HOLD_CYC
) (
   // clock and power-on reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // reset sources
   input  wire logic        external_reset_n,
   input  wire logic        wdt_timeout,
   input  wire logic        low_volt,
   input  wire logic        brown_out,
   input  wire logic        cpu_reset_req,
   // avalon-mm slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // vector fetch port
   output logic             vec_rd,
   output logic [31:0]      vec_addr,
   input  wire logic [31:0] vec_data,
   // chip reset outputs
   output logic             chip_reset_b,
   output logic             xtal_reset_b,
   output logic [31:0]      main_stack_pointer,
   output logic [31:0]      reset_entry,
   output logic             boot_select,
   output logic             irq
);
   import src_pkg::*;

   // the hold counter is 16 bits wide and must count at least once
   if (HOLD_CYC < 1 || HOLD_CYC > 65535) begin
      $error("HOLD_CYC out of range");
   end

   ////////////////////////////////////////////////////////////////////
   // reset release and pin conditioning

   logic r1_q, r2_q;   // two-stage reset release
   logic rst_sync_b;   // synchronised reset for the rest
   logic pin_lvl;      // filtered external reset level

   // release power-on reset through two flops
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         r1_q <= 1'b0;
         r2_q <= 1'b0;
      end else begin
         r1_q <= 1'b1;
         r2_q <= r1_q;
      end
   end
   assign rst_sync_b = r2_q;

   // pin arrives asynchronously; pull-up means idle high
   src_sync3 #(.RST_VAL(1'b1)) u_pin_sync (
      .clk_sys    (clk_sys),
      .rst_sync_b (rst_sync_b),
      .async_in   (external_reset_n),
      .level_out  (pin_lvl)
   );

   ////////////////////////////////////////////////////////////////////
   // register bus decode

   logic [2:0]  reg_idx;   // word index
   logic        hit;       // valid register
   logic        wr_en;     // accepted write
   logic        rd_en;     // accepted read
   assign reg_idx = avs_address[4:2];
   assign hit     = (reg_idx <= `SRC_REG_VEC_BASE);
   // answer every access in the cycle presented, no waits needed
   assign avs_waitrequest = 1'b0;
   assign wr_en = avs_write && hit;
   assign rd_en = avs_read;

   logic sys_req;    // software system reset request
   logic cpu_sw_req; // software cpu reset request
   assign sys_req    = wr_en && (reg_idx == `SRC_REG_SWRST)
                       && avs_writedata[`SRC_SWRST_SYS_BIT];
   assign cpu_sw_req = wr_en && (reg_idx == `SRC_REG_SWRST)
                       && avs_writedata[`SRC_SWRST_CPU_BIT];

   ////////////////////////////////////////////////////////////////////
   // reset event gathering

   src_flags_t ev;       // source events, active while the source is
   logic       any_ev;   // any source active this cycle
   // pin counts while low, the rest on their level or request
   assign ev[`SRC_BIT_POR] = 1'b0;
   assign ev[`SRC_BIT_PIN] = !pin_lvl;
   assign ev[`SRC_BIT_WDT] = wdt_timeout;
   assign ev[`SRC_BIT_LVR] = low_volt;
   assign ev[`SRC_BIT_BOD] = brown_out;
   assign ev[`SRC_BIT_CPU] = cpu_reset_req || cpu_sw_req;
   assign ev[`SRC_BIT_SYS] = sys_req;
   assign any_ev = |ev;

   // a filtered low pin must leave its own cause flag behind
   AST_PIN_FLAG: assert property (@(posedge clk_sys) disable iff
      (!rst_sync_b) !pin_lvl |=> flags_q[`SRC_BIT_PIN])
      else $error("pin low did not set its cause flag");

   ////////////////////////////////////////////////////////////////////
   // sequencer: hold, then fetch vectors 0 and 1

   src_state_t st_q, st_d;
   logic [15:0] cnt_q;     // hold countdown
   logic        fidx_q;    // fetch index: 0 stack, 1 reset entry
   logic        fwait_q;   // fetch issued last cycle
   logic        por_seen_q;// first run after power-on

   // next state
   always_comb begin
      st_d = st_q;
      case (st_q)
         SRC_ST_RUN:   if (any_ev) st_d = SRC_ST_HOLD;
         SRC_ST_HOLD:  if (!any_ev && cnt_q == 16'h0001)
                          st_d = SRC_ST_FETCH;
         SRC_ST_FETCH: if (any_ev) st_d = SRC_ST_HOLD;
                       else if (fwait_q && fidx_q) st_d = SRC_ST_RUN;
         default:      st_d = SRC_ST_HOLD;
      endcase
   end

   // state and counter; power-on starts in hold
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         st_q  <= SRC_ST_HOLD;
         cnt_q <= 16'(HOLD_CYC);
      end else begin
         st_q <= st_d;
         if (any_ev) cnt_q <= 16'(HOLD_CYC);
         else if (st_q == SRC_ST_HOLD && cnt_q != 16'h0001)
            cnt_q <= cnt_q - 16'h0001;
      end
   end

   // vector fetch: word 0 then word 1 of the table at base zero
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         fidx_q  <= 1'b0;
         fwait_q <= 1'b0;
      end else if (st_q != SRC_ST_FETCH) begin
         fidx_q  <= 1'b0;
         fwait_q <= 1'b0;
      end else if (fwait_q) begin
         fidx_q  <= 1'b1;
         fwait_q <= 1'b0;
      end else begin
         fwait_q <= 1'b1;
      end
   end
   assign vec_rd   = (st_q == SRC_ST_FETCH) && !fwait_q;
   assign vec_addr = `SRC_VEC_BASE + {29'h0, fidx_q, 2'b00};

   // capture fetched words
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         main_stack_pointer <= 32'h0000_0000;
         reset_entry        <= 32'h0000_0000;
      end else if (st_q == SRC_ST_FETCH && fwait_q) begin
         if (!fidx_q) main_stack_pointer <= vec_data;
         else         reset_entry        <= vec_data;
      end
   end

   // whole chip held while not running
   assign chip_reset_b = (st_q == SRC_ST_RUN);
   // crystal only reset by power-on
   assign xtal_reset_b = por_seen_q;

   ////////////////////////////////////////////////////////////////////
   // cause flags, boot select, interrupt status

   src_flags_t flags_q, flags_d;  // reset cause flags
   src_flags_t ist_q, ist_d;      // interrupt status
   src_flags_t imask_q;           // interrupt mask
   logic       boot_q;            // boot select
   logic       w1c;
   assign w1c = wr_en && (reg_idx == `SRC_REG_FLAGS);
   // set wins over a write-one clear
   assign flags_d = (flags_q & ~(w1c ? avs_writedata[6:0] : 7'h00))
                    | ev;
   // read of status clears, a new event still wins
   assign ist_d = ((rd_en && reg_idx == `SRC_REG_IRQ_STAT) ?
                   7'h00 : ist_q) | ev;

   // power-on sets its own flag; power-on or a write-one clear clears the flags
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         flags_q    <= 7'h01;
         ist_q      <= 7'h01;
         imask_q    <= 7'h00;
         boot_q     <= 1'b0;
         por_seen_q <= 1'b0;
      end else begin
         flags_q    <= flags_d;
         ist_q      <= ist_d;
         por_seen_q <= 1'b1;
         if (wr_en && reg_idx == `SRC_REG_IRQ_MASK)
            imask_q <= avs_writedata[6:0];
         // boot select kept across system reset
         if (wr_en && reg_idx == `SRC_REG_ISPCTL)
            boot_q <= avs_writedata[`SRC_ISP_BOOT_BIT];
      end
   end
   assign boot_select = boot_q;
   assign irq = |(ist_q & imask_q);

   ////////////////////////////////////////////////////////////////////
   // read mux

   logic [31:0] rd_mux;
   always_comb begin
      case (reg_idx)
         `SRC_REG_FLAGS:    rd_mux = {25'h0, flags_q};
         `SRC_REG_ISPCTL:   rd_mux = {30'h0, boot_q, 1'b0};
         `SRC_REG_IRQ_STAT: rd_mux = {25'h0, ist_q};
         `SRC_REG_IRQ_MASK: rd_mux = {25'h0, imask_q};
         `SRC_REG_XTAL:     rd_mux = {31'h0, por_seen_q};
         `SRC_REG_VEC_BASE: rd_mux = `SRC_VEC_BASE;
         default:           rd_mux = 32'h0000_0000;
      endcase
   end
   // read data presented combinationally with waitrequest low
   assign avs_readdata = rd_en ? rd_mux : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////
   // checks

   AST_PIN_HOLDS: assert property (@(posedge clk_sys) disable iff
      (!rst_sync_b) !pin_lvl |=> !chip_reset_b)
      else $error("pin low did not hold chip reset");
   AST_EV_RESET: assert property (@(posedge clk_sys) disable iff
      (!rst_sync_b) any_ev |=> (st_q == SRC_ST_HOLD))
      else $error("event did not start reset");
   AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff
      (!rst_sync_b) wdt_timeout |=> flags_q[`SRC_BIT_WDT])
      else $error("watchdog flag not set");
   AST_SYS_FULL: assert property (@(posedge clk_sys) disable iff
      (!rst_sync_b) sys_req |=> !chip_reset_b [*2])
      else $error("system reset did not hold chip");
   AST_XTAL_KEEP: assert property (@(posedge clk_sys) disable iff
      (!rst_sync_b) sys_req |=> xtal_reset_b && $stable(boot_q))
      else $error("system reset touched crystal or boot select");
   AST_VEC_ZERO: assert property (@(posedge clk_sys) disable iff
      (!rst_sync_b) vec_rd && !fidx_q |-> vec_addr == 32'h0)
      else $error("stack fetch not at base zero");
   AST_VEC_ORDER: assert property (@(posedge clk_sys) disable iff
      (!rst_sync_b) (st_q == SRC_ST_FETCH) && fwait_q && !fidx_q
      && !any_ev |=> main_stack_pointer == $past(vec_data)
      ##1 vec_addr == 32'h4)
      else $error("vector order wrong");
   AST_STICKY: assert property (@(posedge clk_sys) disable iff
      (!rst_sync_b) flags_q[`SRC_BIT_PIN] && !w1c
      |=> flags_q[`SRC_BIT_PIN])
      else $error("cause flag lost without clear");

   COV_PIN: cover property (@(posedge clk_sys) disable iff
      (!rst_sync_b) !pin_lvl ##[1:200] chip_reset_b);
   COV_SYS: cover property (@(posedge clk_sys) disable iff
      (!rst_sync_b) sys_req ##[1:200] chip_reset_b);
   COV_IRQ: cover property (@(posedge clk_sys) disable iff
      (!rst_sync_b) irq);
endmodule

/* inc/src_consts.svh */
/*
 reset controller constants: register offsets, field positions, reset
 values and timing counts. assumes a 50 MHz system clock.
*/
// Notes on behaviour
// - external reset pin active low, pulled up
// - seven events start a chip reset
// - per-event cause flag readable by software
// - power-on resets everything, system reset resets the chip
// - system reset keeps crystal and boot-select bit
// - vector table base fixed at zero
// - table holds stack pointer then handler entries
// - vector zero is main stack pointer
`ifndef SRC_CONSTS_SVH
`define SRC_CONSTS_SVH

// register word offsets (byte address = 4 * index)
`define SRC_REG_FLAGS     3'h0
`define SRC_REG_ISPCTL    3'h1
`define SRC_REG_SWRST     3'h2
`define SRC_REG_IRQ_STAT  3'h3
`define SRC_REG_IRQ_MASK  3'h4
`define SRC_REG_XTAL      3'h5
`define SRC_REG_VEC_BASE  3'h6

// flag bit positions, one per reset source
`define SRC_BIT_POR       0
`define SRC_BIT_PIN       1
`define SRC_BIT_WDT       2
`define SRC_BIT_LVR       3
`define SRC_BIT_BOD       4
`define SRC_BIT_CPU       5
`define SRC_BIT_SYS       6
`define SRC_NUM_SRC       7

// isp control and software reset fields
`define SRC_ISP_BOOT_BIT  1
`define SRC_SWRST_SYS_BIT 0
`define SRC_SWRST_CPU_BIT 1

// fixed vector table base
`define SRC_VEC_BASE      32'h0000_0000

// reset pulse stretch time in ns and derived cycle count
`define SRC_CLK_NS        20
`define SRC_HOLD_NS       400
`define SRC_HOLD_CYC      ((`SRC_HOLD_NS + `SRC_CLK_NS - 1) / `SRC_CLK_NS)

`endif

/* inc/src_pkg.sv */
/*
 types for the reset controller. assumes src_consts.svh beside it.
*/
package src_pkg;
   // sequencer states
   typedef enum logic [1:0] {
      SRC_ST_RUN,
      SRC_ST_HOLD,
      SRC_ST_FETCH
   } src_state_t;
   typedef logic [6:0] src_flags_t;
endpackage

/* hdl/src_sync3.sv */
/*
 three-stage synchroniser with agreement filter for one pin level.
 assumes input is asynchronous to clk_sys.
*/
module src_sync3 #(
   parameter logic RST_VAL = 1'b1
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_sync_b,
   // level in and filtered level out
   input  wire logic async_in,
   output logic      level_out
);
   logic s1_q, s2_q, s3_q; // chain; s1 only feeds s2
   logic lvl_q;            // accepted level

   // shift chain
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // change counts only once stage two and three agree
   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) lvl_q <= RST_VAL;
      else if (s2_q == s3_q) lvl_q <= s3_q;
   end

   assign level_out = lvl_q;
endmodule

/* verification/src_vec_mem.sv */
/*
 vector table model on the controller's fetch port.
 assumes a fetch is answered one cycle after vec_rd.
*/
module src_vec_mem (
   // clock
   input  wire logic        clk_sys,
   // fetch port
   input  wire logic        vec_rd,
   input  wire logic [31:0] vec_addr,
   output logic [31:0]      vec_data,
   // table words chosen by the bench
   input  wire logic [31:0] sp_val,
   input  wire logic [31:0] entry_val
);
   timeunit 1ns;
   timeprecision 1ps;
   initial vec_data = 32'h0;
   ////////////////////////////////////////////////////////////////////
   // base fixed at zero: word 0 stack pointer, word 1 reset entry
   always @(posedge clk_sys) begin
      if (vec_rd) begin
         case (vec_addr)
            32'h0000_0000: vec_data <= sp_val;
            32'h0000_0004: vec_data <= entry_val;
            default:       vec_data <= ~vec_addr;
         endcase
      end else begin
         vec_data <= ~vec_data; // no stale word outside the data phase
      end
   end
endmodule

/* verification/testbench.sv */
/*
 self-checking bench for the reset controller with a flag model.
 assumes the vector table model and a 50 MHz clock.
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // stimulus and observed pins
   logic        clk_sys, rst_b, external_reset_n, wdt_timeout;
   logic        low_volt, brown_out, cpu_reset_req, avs_read, avs_write;
   logic [4:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, vec_addr, vec_data;
   logic        avs_waitrequest, vec_rd, chip_reset_b, xtal_reset_b;
   logic [31:0] main_stack_pointer, reset_entry, sp_val, entry_val, rd;
   logic        boot_select, irq, armed, xtal_bad;
   int          err_count, cmp_count, seed, exp_flags, i;
   ////////////////////////////////////////////////////////////////////
   src_reset_ctrl #(.HOLD_CYC(2)) DUT (.clk_sys(clk_sys), .rst_b(rst_b),
      .external_reset_n(external_reset_n), .wdt_timeout(wdt_timeout),
      .low_volt(low_volt), .brown_out(brown_out),
      .cpu_reset_req(cpu_reset_req), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .vec_rd(vec_rd),
      .vec_addr(vec_addr), .vec_data(vec_data),
      .chip_reset_b(chip_reset_b), .xtal_reset_b(xtal_reset_b),
      .main_stack_pointer(main_stack_pointer),
      .reset_entry(reset_entry), .boot_select(boot_select), .irq(irq));
   src_vec_mem u_mem (.clk_sys(clk_sys), .vec_rd(vec_rd),
      .vec_addr(vec_addr), .vec_data(vec_data), .sp_val(sp_val),
      .entry_val(entry_val));
   ////////////////////////////////////////////////////////////////////
   // 50 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // crystal reset must stay off outside power-on
   always @(negedge clk_sys) begin
      if (armed && xtal_reset_b !== 1'b1) xtal_bad <= 1'b1;
   end
   // hang guard, far beyond the planned run
   initial begin
      #400000;
      err_count++;
      final_report();
   end
   ////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("checks %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   // one avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr, input int idx, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address   <= 5'(idx * 4);
      avs_write     <= wr;
      avs_read      <= !wr;
      avs_writedata <= d;
      // ends once waitrequest is seen low, else the hang guard ends it
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      // let a written register settle before anyone looks at it
      @(negedge clk_sys);
   endtask
   // wait for run state, then check fetched table words
   task automatic wait_run;
      int n;
      n = 0;
      while (chip_reset_b !== 1'b1 && n < 300) begin
         @(negedge clk_sys);
         n++;
      end
      chk("chip_run", 32'h1, {31'h0, chip_reset_b});
      chk("stack_ptr", sp_val, main_stack_pointer);
      chk("entry", entry_val, reset_entry);
      bus(0, 0, 32'h0);
      chk("flags", 32'(exp_flags), rd);
   endtask
   // raise one source: 1 pin .. 5 cpu line, 6 system, 7 cpu by register
   task automatic fire(input int b);
      int n;
      sp_val    <= $random(seed);
      entry_val <= $random(seed);
      if (b >= 6) begin
         bus(1, 2, (b == 6) ? 32'h1 : 32'h2);
      end else begin
         @(posedge clk_sys);
         external_reset_n <= (b != 1);
         wdt_timeout      <= (b == 2);
         low_volt         <= (b == 3);
         brown_out        <= (b == 4);
         cpu_reset_req    <= (b == 5);
         repeat ((b == 1) ? 30 : 1) @(posedge clk_sys);
         external_reset_n <= 1'b1;
         {wdt_timeout, low_volt, brown_out, cpu_reset_req} <= 4'h0;
      end
      n = 0;
      while (chip_reset_b !== 1'b0 && n < 30) begin
         @(negedge clk_sys);
         n++;
      end
      chk("reset_taken", 32'h0, {31'h0, chip_reset_b});
      exp_flags |= 1 << ((b == 7) ? 5 : b);
      wait_run();
      chk("boot_kept", 32'h1, {31'h0, boot_select});
      chk("xtal_kept", 32'h0, {31'h0, xtal_bad});
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      seed = 32'h8ab6eb13;
      {err_count, cmp_count, armed, xtal_bad} = 0;
      {wdt_timeout, low_volt, brown_out, cpu_reset_req} = 4'h0;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      external_reset_n = 1'b1;
      sp_val = 32'h2000_0400;
      entry_val = 32'h0000_00c1;
      rst_b = 1'b0;
      exp_flags = 1;
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      wait_run();
      armed = 1'b1;
      chk("boot_por", 32'h0, {31'h0, boot_select});
      bus(0, 5, 32'h0);
      chk("xtal_run", 32'h1, rd);
      bus(0, 6, 32'h0);
      chk("vec_base", 32'h0, rd);
      bus(1, 7, $random(seed));
      bus(0, 7, 32'h0);
      chk("unmapped", 32'h0, rd);
      bus(1, 1, 32'h2);
      chk("boot_set", 32'h1, {31'h0, boot_select});
      // interrupt: unmasked event raises, masked one stays quiet
      bus(1, 4, 32'h4);
      bus(0, 3, 32'h0);
      chk("irq_por", 32'h1, rd);
      fire(2);
      chk("irq_on", 32'h1, {31'h0, irq});
      bus(0, 3, 32'h0);
      chk("irq_stat", 32'h4, rd);
      fire(3);
      chk("irq_mask", 32'h0, {31'h0, irq});
      bus(0, 3, 32'h0);
      chk("irq_stat2", 32'h8, rd);
      for (i = 1; i <= 7; i++) fire(i);
      // write-one-to-clear with random pattern, then all
      rd = $random(seed);
      exp_flags &= ~int'(rd[6:0]);
      bus(1, 0, rd);
      bus(0, 0, 32'h0);
      chk("w1c", 32'(exp_flags), rd);
      bus(1, 0, 32'h7f);
      bus(0, 0, 32'h0);
      chk("w1c_all", 32'h0, rd);
      // second power-on mid-run resets crystal and boot bit
      armed = 1'b0;
      @(posedge clk_sys);
      rst_b <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("xtal_por", 32'h0, {31'h0, xtal_reset_b});
      chk("chip_por", 32'h0, {31'h0, chip_reset_b});
      rst_b <= 1'b1;
      exp_flags = 1;
      wait_run();
      chk("boot_por2", 32'h0, {31'h0, boot_select});
      final_report();
   end
endmodule
